// File: rpc_pin_control.sv
// Reset pin sequencer, multifunction pin, reference clock out and stop flag.
// Assumes synchronous pin inputs, one clock, and a serial engine that issues
// one-cycle read and write strobes to the register port.
//
// What this block does
// - Irq select 0 gives rate-selected square wave
// - Irq select 1 pulls pin on enabled alarm
// - Irq select bit is 1 after power-up
// - Multifunction pin only pulled low or released
// - Irq select bit lives in register 0x0e
// - Reset pin low while supply below threshold
// - Hold reset low for recovery, then release
// - Debounce button press, then assert reset
// - Oscillator disabled skips the recovery delay
// - Recovery delay only with oscillator enabled, running
// - Reset pin does not disturb internal state
// - Reference clock output when enabled, any supply
// - Stop flag set at reset, else only after stop detect interval
// - Recovery interval is about 250 ms
// - After debounce, wait release, pulse 250 ms
// - Stop detect interval is about 100 ms
`timescale 1ns/1ps
module rpc_pin_control
  import rpc_pkg::*;
#(
  parameter int unsigned REC_CYC   = REC_CYCLES,   // Recovery delay in cycles
  parameter int unsigned DEB_CYC   = DEB_CYCLES,   // Debounce time in cycles
  parameter int unsigned PULSE_CYC = PULSE_CYCLES, // Reset pulse in cycles
  parameter int unsigned OSF_CYC   = OSF_CYCLES    // Stop detect in cycles
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire rpc_req_t   reg_req,          // Register access from serial engine
  output logic [7:0]      reg_rdata_q,      // Read data, valid cycle after read
  input  wire logic       vcc_ok,           // Supply above power fail threshold
  input  wire logic       osc_running,      // Oscillator is running
  input  wire logic       ref_clk_in,       // Oscillator reference clock level
  input  wire logic       ref_clk_en,       // Reference clock output enable
  input  wire logic [1:0] alarm_match,      // Alarm match flags from comparators
  input  wire logic       osf_clear,        // Clear of the oscillator stop flag
  output logic            osc_stopped_flag, // Sticky oscillator stop flag
  input  wire logic       rst_pin_in,       // Reset pin level
  output logic            rst_pin_out,      // Reset pin drive value
  output logic            rst_pin_oe,       // Reset pin pulled low
  output logic            irq_or_square_out,// Multifunction pin drive value
  output logic            irq_or_square_oe, // Multifunction pin pulled low
  output logic            ref_clock_out,    // Reference clock drive value
  output logic            ref_clock_oe      // Reference clock pin pulled low
);

  // ***************************************************************
  // Parameter checks
  // ***************************************************************
  initial begin
    if (REC_CYC < 2 || DEB_CYC < 2 || PULSE_CYC < 2 || OSF_CYC < 2)
      $error("rpc_pin_control: delay counts must be at least 2");
    if (REC_CYC >= (1 << TIMER_W) || DEB_CYC >= (1 << TIMER_W) ||
        PULSE_CYC >= (1 << TIMER_W) || OSF_CYC >= (1 << TIMER_W))
      $error("rpc_pin_control: delay counts exceed timer width");
  end

  // ***************************************************************
  // Control register
  // ***************************************************************
  rpc_ctrl_t ctrl_q; // Control register contents

  // Write decode; the reset pin never touches this register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= rpc_ctrl_t'(CONTROL_REG_RESET);
    end else if (reg_req.wr && reg_req.addr == CONTROL_REG_ADDR) begin
      ctrl_q <= rpc_ctrl_t'(reg_req.wdata);
    end
  end

  // Read decode, unmapped offsets read as zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= UNMAPPED_RDATA;
    end else if (reg_req.rd) begin
      if (reg_req.addr == CONTROL_REG_ADDR) begin
        reg_rdata_q <= ctrl_q;
      end else begin
        reg_rdata_q <= UNMAPPED_RDATA;
      end
    end
  end

  // ***************************************************************
  // Reset pin sequencer
  // ***************************************************************
  rpc_rst_state_t     st_q;        // Sequencer state
  rpc_rst_state_t     st_d;        // Next state
  logic               pin_prev_q;  // Reset pin level last cycle
  logic               tmr_start;   // Start the delay timer
  logic               tmr_abort;   // Stop the delay timer
  logic [TIMER_W-1:0] tmr_load;    // Delay to run
  logic               tmr_done;    // Delay expired
  logic               pin_fall;    // Falling edge on reset pin
  logic               pin_rise;    // Rising edge on reset pin
  logic               rec_needed;  // Oscillator on and running

  assign pin_fall   = pin_prev_q && !rst_pin_in;
  assign pin_rise   = !pin_prev_q && rst_pin_in;
  assign rec_needed = !ctrl_q.osc_disable_bit && osc_running;

  // Previous pin level for edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= rst_pin_in;
    end
  end

  // Next state and timer control
  always_comb begin
    st_d      = st_q;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    tmr_load  = '0;
    if (!vcc_ok) begin
      // Power fail overrides everything
      st_d      = RS_PF;
      tmr_abort = 1'b1;
    end else begin
      case (st_q)
        RS_PF: begin
          if (rec_needed) begin
            st_d      = RS_REC;
            tmr_start = 1'b1;
            tmr_load  = TIMER_W'(REC_CYC);
          end else begin
            st_d = RS_IDLE;
          end
        end
        RS_REC: begin
          if (tmr_done) st_d = RS_IDLE;
        end
        RS_IDLE: begin
          if (pin_fall) begin
            st_d      = RS_DEB;
            tmr_start = 1'b1;
            tmr_load  = TIMER_W'(DEB_CYC);
          end
        end
        RS_DEB: begin
          if (tmr_done) st_d = RS_WAIT;
        end
        RS_WAIT: begin
          if (pin_rise) begin
            st_d      = RS_PULSE;
            tmr_start = 1'b1;
            tmr_load  = TIMER_W'(PULSE_CYC);
          end
        end
        RS_PULSE: begin
          if (tmr_done) st_d = RS_IDLE;
        end
        default: begin
          st_d = RS_PF;
        end
      endcase
    end
  end

  // State register, starts as after a power fail
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= RS_PF;
    end else begin
      st_q <= st_d;
    end
  end

  // Open-drain reset drive follows the next state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pin_oe  <= 1'b1;
      rst_pin_out <= 1'b0;
    end else begin
      rst_pin_oe  <= (st_d != RS_IDLE) && (st_d != RS_WAIT);
      rst_pin_out <= 1'b0;
    end
  end

  // Shared delay timer for recovery, debounce and pulse
  rpc_delay_timer #(
    .W (TIMER_W)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (tmr_start),
    .abort   (tmr_abort),
    .load    (tmr_load),
    .done    (tmr_done)
  );

  // ***************************************************************
  // Multifunction pin
  // ***************************************************************
  logic                ref_prev_q; // Reference clock level last cycle
  logic [SQ_DIV_W-1:0] sq_div_q;   // Oscillator edge counter
  logic                sq_bit;     // Selected square wave level
  logic                irq_active; // Enabled alarm has matched

  // Count oscillator rising edges for the square wave divider
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_prev_q <= 1'b0;
      sq_div_q   <= '0;
    end else begin
      ref_prev_q <= ref_clk_in;
      if (ref_clk_in && !ref_prev_q) sq_div_q <= sq_div_q + SQ_DIV_W'(1);
    end
  end

  // Rate select picks a divider tap
  always_comb begin
    case ({ctrl_q.rate_select_high, ctrl_q.rate_select_low})
      2'b00:   sq_bit = sq_div_q[SQ_TAP_1H];
      2'b01:   sq_bit = sq_div_q[SQ_TAP_1K];
      2'b10:   sq_bit = sq_div_q[SQ_TAP_4K];
      default: sq_bit = sq_div_q[SQ_TAP_8K];
    endcase
  end

  assign irq_active = |(alarm_match & ctrl_q.alarm_enable);

  // Pin is pulled low or released, never driven high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_or_square_oe  <= 1'b0;
      irq_or_square_out <= 1'b0;
    end else begin
      irq_or_square_out <= 1'b0;
      if (ctrl_q.irq_select_bit) begin
        irq_or_square_oe <= irq_active;
      end else begin
        irq_or_square_oe <= !sq_bit;
      end
    end
  end

  // ***************************************************************
  // Reference clock output
  // ***************************************************************
  // Open-drain copy of the oscillator when enabled, on either supply
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_clock_oe  <= 1'b0;
      ref_clock_out <= 1'b0;
    end else begin
      ref_clock_oe  <= ref_clk_en && !ref_clk_in;
      ref_clock_out <= 1'b0;
    end
  end

  // ***************************************************************
  // Oscillator stop detection
  // ***************************************************************
  logic [TIMER_W-1:0] stop_cnt_q; // Cycles the oscillator has been stopped

  // Count stopped cycles, reset as soon as it runs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_cnt_q <= '0;
    end else if (osc_running) begin
      stop_cnt_q <= '0;
    end else if (stop_cnt_q < TIMER_W'(OSF_CYC)) begin
      stop_cnt_q <= stop_cnt_q + TIMER_W'(1);
    end
  end

  // Sticky flag, a new detection wins over a clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_stopped_flag <= 1'b1;
    end else if (stop_cnt_q == TIMER_W'(OSF_CYC - 1) && !osc_running) begin
      osc_stopped_flag <= 1'b1;
    end else if (osf_clear) begin
      osc_stopped_flag <= 1'b0;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  sequence s_supply_back;
    (st_q == RS_PF) && vcc_ok;
  endsequence

  a_pf_holds_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !vcc_ok |=> rst_pin_oe && st_q == RS_PF)
    else $error("reset pin not low during power fail");

  a_rec_keeps_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_supply_back ##0 rec_needed |=> rst_pin_oe ##1 (rst_pin_oe || !vcc_ok))
    else $error("recovery did not hold reset low");

  a_bypass_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_supply_back ##0 ctrl_q.osc_disable_bit |=> !rst_pin_oe)
    else $error("recovery not bypassed with oscillator off");

  a_press_debounce: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q == RS_IDLE) && vcc_ok && pin_fall |=> rst_pin_oe && st_q == RS_DEB)
    else $error("button press not debounced with reset low");

  a_release_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q == RS_WAIT) && vcc_ok && pin_rise |=> rst_pin_oe [*2])
    else $error("button release did not start reset pulse");

  a_irq_mode_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_q.irq_select_bit && irq_active |=> irq_or_square_oe)
    else $error("enabled alarm did not pull pin low");

  a_sq_mode_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl_q.irq_select_bit |=> irq_or_square_oe == !$past(sq_bit))
    else $error("square wave not on pin");

  a_open_drain_pins: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !irq_or_square_out && !rst_pin_out && !ref_clock_out)
    else $error("open-drain pin driven high");

  a_ref_clock_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ref_clk_en && !ref_clk_in |=> ref_clock_oe)
    else $error("reference clock not presented");

  a_osf_waits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !osc_stopped_flag && stop_cnt_q < TIMER_W'(OSF_CYC - 1) |=> !osc_stopped_flag)
    else $error("stop flag set before detect interval");

  a_ctrl_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_req.wr && reg_req.addr == CONTROL_REG_ADDR
    |=> ctrl_q.irq_select_bit == $past(reg_req.wdata[2]))
    else $error("control register write lost");

endmodule // rpc_pin_control

// File: rpc_pkg.sv
// Shared constants, types and timing figures of the reset and pin output control block.
// Assumes a single 125 MHz system clock and synchronous pin inputs.
package rpc_pkg;

  // ***************************************************************
  // Clock and timing
  // ***************************************************************
  localparam int unsigned CLK_KHZ        = 125000; // System clock rate in kHz
  localparam int unsigned REC_TIME_MS    = 250;    // Power-up recovery delay
  localparam int unsigned DEB_TIME_MS    = 250;    // Button debounce time
  localparam int unsigned PULSE_TIME_MS  = 250;    // Pushbutton reset pulse
  localparam int unsigned OSF_TIME_MS    = 100;    // Oscillator stop detect time
  localparam int unsigned TIMER_W        = 25;     // Width of the delay counters

  // Whole cycles in a time given in ms (rounded down; figures are exact)
  function automatic int unsigned ms_to_cycles(input int unsigned ms);
    longint unsigned prod;
    prod = longint'(ms) * longint'(CLK_KHZ);
    return int'(prod);
  endfunction

  localparam int unsigned REC_CYCLES   = ms_to_cycles(REC_TIME_MS);
  localparam int unsigned DEB_CYCLES   = ms_to_cycles(DEB_TIME_MS);
  localparam int unsigned PULSE_CYCLES = ms_to_cycles(PULSE_TIME_MS);
  localparam int unsigned OSF_CYCLES   = ms_to_cycles(OSF_TIME_MS);

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] CONTROL_REG_ADDR  = 8'h0e; // Control register offset
  localparam logic [7:0] CONTROL_REG_RESET = 8'h1c; // Irq select and rate bits set
  localparam logic [7:0] UNMAPPED_RDATA    = 8'h00; // Other offsets read as zero

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       osc_disable_bit;   // Oscillator off
    logic       batt_square_en;    // Square wave on backup supply
    logic       convert_temp;      // Temperature conversion request
    logic       rate_select_high;  // Rate select, upper bit
    logic       rate_select_low;   // Rate select, lower bit
    logic       irq_select_bit;    // 1: interrupt, 0: square wave
    logic [1:0] alarm_enable;      // Per alarm interrupt enable
  } rpc_ctrl_t;

  // Read or write request toward the register file
  typedef struct packed {
    logic       wr;    // Write strobe, one cycle
    logic       rd;    // Read strobe, one cycle
    logic [7:0] addr;  // Register offset
    logic [7:0] wdata; // Write data
  } rpc_req_t;

  // Square wave taps into the oscillator edge counter, per rate code
  localparam int unsigned SQ_DIV_W = 15;
  localparam int unsigned SQ_TAP_8K = 1;  // 8.192 kHz
  localparam int unsigned SQ_TAP_4K = 2;  // 4.096 kHz
  localparam int unsigned SQ_TAP_1K = 4;  // 1.024 kHz
  localparam int unsigned SQ_TAP_1H = 14; // 1 Hz

  // Reset pin sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    RS_IDLE  = 3'b000, // Pin released, watching for a press
    RS_DEB   = 3'b001, // Debounce, pin pulled low
    RS_WAIT  = 3'b011, // Released, waiting for button release
    RS_PULSE = 3'b010, // Reset pulse, pin pulled low
    RS_PF    = 3'b110, // Supply below threshold, pin low
    RS_REC   = 3'b111  // Recovery after supply returns
  } rpc_rst_state_t;

endpackage

// File: rpc_delay_timer.sv
// Down-counting delay timer with load and one-cycle done pulse.
// Assumes the caller holds the load value stable only on the start cycle.
`timescale 1ns/1ps
module rpc_delay_timer
  import rpc_pkg::*;
#(
  parameter int unsigned W = TIMER_W
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         start,   // Load and run
  input  wire logic         abort,   // Stop without done
  input  wire logic [W-1:0] load,    // Cycles to run
  output logic              done     // One cycle pulse at expiry
);

  // ***************************************************************
  // Counter
  // ***************************************************************
  logic [W-1:0] count_q; // Remaining cycles
  logic         run_q;   // Counting

  initial begin
    if (W < 2) $error("rpc_delay_timer: width too small");
  end

  // Load, count down, flag expiry
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      run_q   <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        run_q <= 1'b0;
      end else if (start) begin
        count_q <= load;
        run_q   <= 1'b1;
      end else if (run_q) begin
        if (count_q <= W'(1)) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end else begin
          count_q <= count_q - W'(1);
        end
      end
    end
  end

endmodule // rpc_delay_timer

// File: rpc_button_model.sv
// Pushbutton switch and host reset input sitting on the open-drain reset pin.
// Assumes an internal pull-up on the pin and that the block pulls low through oe.
`timescale 1ns/1ps
module rpc_button_model (
  input  wire logic sys_clk,
  input  wire logic press,      // Button held down
  input  wire logic rst_pin_oe, // Block pulls pin low
  output logic      rst_pin_in, // Resolved pin level
  output int        low_run     // Length of the last low period seen by host
);
  int run_q; // Cycles low so far

  initial begin
    run_q   = 0;
    low_run = 0;
  end

  // Switch can only pull low; the pull-up wins otherwise
  assign rst_pin_in = !(rst_pin_oe || press);

  // Host input: measure each low period of the pin
  always @(posedge sys_clk) begin
    if (!rst_pin_in) begin
      run_q <= run_q + 1;
    end else if (run_q != 0) begin
      low_run <= run_q;
      run_q   <= 0;
    end
  end
endmodule // rpc_button_model

// File: testbench.sv
// Self-checking bench of the reset and pin output control block.
// Assumes short delay parameters and a behavioural button and host model.
`timescale 1ns/1ps
module testbench;
  import rpc_pkg::*;
  localparam int REC = 20, DEB = 20, PUL = 20, OSC_STOPPED_FLAG = 10, LIMIT = 20000;
  logic       sys_clk, rst_n, vcc_ok, osc_running, ref_clk_in, ref_clk_en, osf_clear;
  logic       press, osc_stopped_flag, rst_pin_in, rst_pin_out, rst_pin_oe;
  logic       irq_or_square_out, irq_or_square_oe, ref_clock_out, ref_clock_oe;
  logic [1:0] alarm_match;
  logic [7:0] reg_rdata_q, rd_v, ctrl_m;
  logic [31:0] rng;
  logic       ref_seen; // Model: reference level at the last edge
  rpc_req_t   reg_req;
  int         low_run, n, chg, n_mismatch, cmp_count, cyc;
  int         sq_m, sq_s, sq_e; // Model: oscillator rising edges, start, expected
  int         taps[4] = '{14, 4, 2, 1}; // Divider tap per rate code

  rpc_pin_control #(.REC_CYC(REC), .DEB_CYC(DEB), .PULSE_CYC(PUL), .OSF_CYC(OSC_STOPPED_FLAG))
    u_rpc_pin_control (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata_q(reg_rdata_q), .vcc_ok(vcc_ok), .osc_running(osc_running),
    .ref_clk_in(ref_clk_in), .ref_clk_en(ref_clk_en), .alarm_match(alarm_match),
    .osf_clear(osf_clear), .osc_stopped_flag(osc_stopped_flag),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .irq_or_square_out(irq_or_square_out), .irq_or_square_oe(irq_or_square_oe),
    .ref_clock_out(ref_clock_out), .ref_clock_oe(ref_clock_oe));

  rpc_button_model u_rpc_button_model (.sys_clk(sys_clk), .press(press),
    .rst_pin_oe(rst_pin_oe), .rst_pin_in(rst_pin_in), .low_run(low_run));

  // ***************************************************************
  // Clock, timeout and helpers
  // ***************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      $display("[ERR] timeout expected end seen cycle %0d", cyc);
      end_sim();
    end
  end

  // Model of the oscillator edge counter that feeds the square wave
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_seen <= 1'b0;
      sq_m     <= 0;
    end else begin
      ref_seen <= ref_clk_in;
      if (ref_clk_in && !ref_seen) sq_m <= sq_m + 1;
    end
  end

  // Next pseudo-random word
  function automatic void rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
  endfunction

  // Advance k edges, then settle
  task automatic step(input int k = 1);
    repeat (k) begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkr(input string nm, input int lo, input int hi, input int g);
    cmp_count++;
    if (g < lo || g > hi) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Register write, one strobe then an idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    step();
    reg_req.wr = 1'b0;
    step();
    if (a == CONTROL_REG_ADDR) ctrl_m = d;
  endtask

  // Register read, data lands the edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step();
    reg_req.rd = 1'b0;
    d = reg_rdata_q;
    step();
  endtask

  // Count cycles until the reset pin drive reaches a level
  task automatic wait_oe(input logic e, output int k);
    k = 0;
    while (rst_pin_oe !== e && k < 200) begin
      step();
      k++;
    end
  endtask

  // Supply dip then return, count cycles to pin release
  task automatic dip(output int k);
    vcc_ok = 1'b0;
    step(3);
    chk1("pf_oe", 1'b1, rst_pin_oe);
    chk1("pf_out", 1'b0, rst_pin_out);
    vcc_ok = 1'b1;
    wait_oe(1'b0, k);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    cyc = 0;
    rng = 32'h00015331;
    rst_n = 1'b0;
    vcc_ok = 1'b1;
    osc_running = 1'b1;
    ref_clk_in = 1'b0;
    ref_clk_en = 1'b0;
    osf_clear = 1'b0;
    press = 1'b0;
    alarm_match = 2'b00;
    reg_req = '0;
    ctrl_m = 8'h1c;
    step(3);
    chk1("reset_oe", 1'b1, rst_pin_oe);
    rst_n = 1'b1;
    wait_oe(1'b0, n);
    chkr("rec_len", REC, REC + 3, n);
    rd(8'h0e, rd_v);
    chk8("ctrl_reset", 8'h1c, rd_v);
    rnd();
    wr(8'h0d, rng[7:0]);
    rd(8'h0f, rd_v);
    chk8("unmapped", 8'h00, rd_v);
    rd(8'h0e, rd_v);
    chk8("ctrl_kept", ctrl_m, rd_v);
    $display("test registers done");
    dip(n);
    chkr("rec_run", REC, REC + 3, n);
    wr(8'h0e, 8'h9c);
    dip(n);
    chkr("bypass_off", 0, 2, n);
    wr(8'h0e, 8'h1c);
    osc_running = 1'b0;
    dip(n);
    chkr("bypass_stop", 0, 2, n);
    osc_running = 1'b1;
    $display("test power done");
    osf_clear = 1'b1;
    step();
    osf_clear = 1'b0;
    step();
    chk1("osf_clr", 1'b0, osc_stopped_flag);
    osc_running = 1'b0;
    step(OSC_STOPPED_FLAG - 2);
    osc_running = 1'b1;
    step(2);
    chk1("osf_short", 1'b0, osc_stopped_flag);
    osc_running = 1'b0;
    step(OSC_STOPPED_FLAG - 2);
    chk1("osf_early", 1'b0, osc_stopped_flag);
    step(4);
    chk1("osf_set", 1'b1, osc_stopped_flag);
    osc_running = 1'b1;
    $display("test stop flag done");
    press = 1'b1;
    step(2);
    chk1("deb_oe", 1'b1, rst_pin_oe);
    step(DEB + 6);
    chk1("deb_rel", 1'b0, rst_pin_oe);
    press = 1'b0;
    step(3);
    chk1("pulse_oe", 1'b1, rst_pin_oe);
    wait_oe(1'b0, n);
    step(2);
    chkr("pulse_len", PUL, PUL + 4, low_run);
    rd(8'h0e, rd_v);
    chk8("ctrl_intact", ctrl_m, rd_v);
    $display("test button done");
    for (int en = 0; en < 4; en++) begin
      wr(8'h0e, 8'h04 | 8'(en));
      repeat (8) begin
        rnd();
        {alarm_match, ref_clk_en, ref_clk_in} = rng[3:0];
        step();
        chk1("irq_oe", |(alarm_match & 2'(en)), irq_or_square_oe);
        chk1("irq_out", 1'b0, irq_or_square_out);
        chk1("ref_oe", ref_clk_en & !ref_clk_in, ref_clock_oe);
        chk1("ref_out", 1'b0, ref_clock_out);
      end
    end
    alarm_match = 2'b00;
    ref_clk_in = 1'b0;
    $display("test interrupt done");
    for (int code = 0; code < 4; code++) begin
      wr(8'h0e, 8'(code) << 3);
      step(4);
      chg = 0;
      sq_s = sq_m;
      rd_v[0] = irq_or_square_oe;
      repeat (132) begin
        ref_clk_in = ~ref_clk_in;
        step();
        if (irq_or_square_oe !== rd_v[0]) chg++;
        rd_v[0] = irq_or_square_oe;
        chk1("sq_out", 1'b0, irq_or_square_out);
      end
      ref_clk_in = 1'b0;
      step(4);
      if (irq_or_square_oe !== rd_v[0]) chg++;
      sq_e = ((sq_s + 66) >> taps[code]) - (sq_s >> taps[code]);
      chkr("sq_changes", sq_e, sq_e, chg);
    end
    $display("test square done");
    end_sim();
  end
endmodule // testbench
